// *** dv/pli_bus_asserts.sv ***
`timescale 1ns/1ps
module pli_bus_asserts
  import pli_pkg::*;
(
  input wire logic       clock,            // Core clock
  input wire logic       rst_n,            // Sync reset
  input wire logic       phy_clock,        // Device bus clock
  input wire logic       link_side_clock,  // Link bus clock
  input wire logic       link_request_out, // Serial request
  input wire logic [1:0] ctl_phy,          // Device control drive
  input wire logic [1:0] ctl_link,         // Link control drive
  input wire logic       phy_oe,           // Device owns buses
  input wire logic       link_oe           // Link owns buses
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Overlapping drive would short the wires
  a_single_bus_owner: assert property (
    !(phy_oe && link_oe)) else $error("both ends drive the buses");
  a_reset_phy_owns: assert property (
    $rose(rst_n) |-> phy_oe && !link_oe && ctl_phy == CTL_IDLE)
    else $error("device not owner after reset");
  a_phy_own_clock: assert property (
    ($changed(ctl_phy) && phy_oe) || $rose(phy_oe) |-> $fell(phy_clock))
    else $error("device drive off its clock");
  a_link_own_clock: assert property (
    ($changed(ctl_link) && link_oe) || $rose(link_oe) |-> $fell(link_side_clock))
    else $error("link drive off its clock");
  a_request_on_clock: assert property (
    $changed(link_request_out) |-> $fell(link_side_clock))
    else $error("request bit off link clock");
  // Half period is ten core cycles
  a_link_clock_half: assert property (
    $rose(link_side_clock) |-> link_side_clock [*8] ##1 link_side_clock [*2]
      ##1 !link_side_clock)
    else $error("link clock half period wrong");
  a_grant_release: assert property (
    $rose(phy_oe && ctl_phy == CTL_GRANT) |->
      ##20 (phy_oe && ctl_phy == CTL_IDLE) ##20 !phy_oe)
    else $error("grant handover sequence wrong");
  a_retake_bound: assert property (
    $fell(link_oe) |-> ##[0:60] phy_oe) else $error("device did not retake bus");

  // Main phases reached
  cover property (phy_oe && ctl_phy == CTL_STATUS);
  cover property (link_oe && ctl_link == CTL_TRANSMIT);
  cover property (phy_oe && ctl_phy == CTL_RECEIVE);
  cover property (phy_oe && ctl_phy == CTL_GRANT);
endmodule : pli_bus_asserts

// *** dv/test_phy_link_interface.sv ***
`timescale 1ns/1ps
module test_phy_link_interface;
  import pli_pkg::*;
  logic       clock, rst_n, physical_layer_reset;        // Clock and resets
  logic       req_valid, tx_valid, tx_last;              // Link user inputs
  logic       dev_valid, dev_last;                       // Receive source
  logic [2:0] req_type;                                  // Request kind
  logic [3:0] req_addr, stat_addr, evt_code, last_sa, last_evt;
  logic [7:0] req_data, tx_data, dev_data, rx_data, stat_data;
  logic [7:0] last_sd, last_grant, first_b;              // Captured values
  logic       req_ready, tx_ready, granted, rx_valid;    // Link results
  logic       rx_first, rx_end, stat_valid, dev_ready, evt_valid;
  logic       lsc_q, oe_q;                               // Edge finders
  int         failures, check_count, i, j, k, m;
  int         rq_n, stat_n, evt_n, grant_n, txr_n, dr_n; // Pulse counts
  int         rx_n, rx_sum, first_n, end_n, back_n, tx_sum, tx_base;
  logic [7:0] wdat [2] = '{8'ha5, 8'h3c};                // Write data
  logic [3:0] wadr [2] = '{4'h0, 4'hf};                  // Edge addresses
  logic [7:0] rxb [4] = '{8'h02, 8'h11, 8'h22, 8'h33};  // Speed then data

  pli_bus_if bus ();
  pli_phy_end pli_phy_end_inst (.clock(clock), .rst_n(rst_n),
    .physical_layer_reset(physical_layer_reset), .bus(bus), .rx_valid(dev_valid),
    .rx_data(dev_data), .rx_last(dev_last), .rx_ready(dev_ready),
    .evt_valid(evt_valid), .evt_code(evt_code));
  pli_link_end pli_link_end_inst (.clock(clock), .rst_n(rst_n), .bus(bus),
    .req_valid(req_valid), .req_type(req_type), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .granted(granted),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_end(rx_end),
    .stat_valid(stat_valid), .stat_addr(stat_addr), .stat_data(stat_data));
  pli_bus_asserts pli_bus_asserts_inst (.clock(clock), .rst_n(rst_n),
    .phy_clock(bus.phy_clock), .link_side_clock(bus.link_side_clock),
    .link_request_out(bus.link_request_out), .ctl_phy(bus.ctl_phy),
    .ctl_link(bus.ctl_link), .phy_oe(bus.phy_oe), .link_oe(bus.link_oe));

  // Core clock, 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Monitors sample on the falling edge, where registers have settled
  always @(negedge clock) begin
    rq_n += int'(req_ready);
    txr_n += int'(tx_ready);
    dr_n += int'(dev_ready);
    grant_n += int'(granted);
    end_n += int'(rx_end);
    if (stat_valid) begin
      stat_n++;
      last_sa = stat_addr;
      last_sd = stat_data;
    end
    if (evt_valid) begin
      evt_n++;
      last_evt = evt_code;
    end
    if (rx_valid) begin
      rx_n++;
      rx_sum += rx_data;
      if (rx_first) begin
        first_n++;
        first_b = rx_data;
      end
    end
    // Grant byte as seen on the wire
    if (bus.phy_oe && bus.phase_control_bus == CTL_GRANT) last_grant = bus.data_bus;
    // One transmit byte per link period, taken mid-period
    if (bus.link_oe && bus.phase_control_bus == CTL_TRANSMIT && !lsc_q
        && bus.link_side_clock) tx_sum += bus.data_bus;
    if (bus.phy_oe && !oe_q) back_n++;
    lsc_q = bus.link_side_clock;
    oe_q = bus.phy_oe;
  end

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Bounded wait on a pulse counter; running out ends the run
  task automatic wait_for(ref int cnt, input int want, input string what);
    for (int n = 0; n < 4000 && cnt < want; n++) tick();
    if (cnt < want) begin
      failures++;
      $display("unexpected %s: expected %0d, seen %0d", what, want, cnt);
      conclude();
    end
  endtask : wait_for

  // Request held until taken; one edge passes before the next
  task automatic send_req(input logic [2:0] t, input logic [3:0] a, input logic [7:0] d);
    int want;
    want = rq_n + 1;
    req_valid = 1'b1;
    req_type = t;
    req_addr = a;
    req_data = d;
    wait_for(rq_n, want, "request taken");
    req_valid = 1'b0;
    tick();
  endtask : send_req

  initial begin
    {req_valid, tx_valid, tx_last, dev_valid, dev_last} = 5'h00;
    {req_type, req_addr, req_data, tx_data, dev_data} = 31'h0;
    physical_layer_reset = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("phy_oe", 1, bus.phy_oe);
    chk("link_oe", 0, bus.link_oe);
    chk("control", CTL_IDLE, bus.phase_control_bus);
    $display("test reset done");
    // Back-to-back writes, then reads at both ends of the address range
    for (i = 0; i < 2; i++) send_req(REQ_WR, wadr[i], wdat[i]);
    for (i = 0; i < 2; i++) begin
      k = stat_n + 1;
      send_req(REQ_RD, wadr[i], 8'h00);
      wait_for(stat_n, k, "status");
      chk("stat_addr", wadr[i], last_sa);
      chk("stat_data", wdat[i], last_sd);
    end
    $display("test register access done");
    send_req(REQ_EVT, 4'ha, 8'h00);
    wait_for(evt_n, 1, "event");
    chk("evt_code", 4'ha, last_evt);
    $display("test event done");
    // Every bus request kind, then three bytes sent by the link
    for (i = 0; i < 4; i++) begin
      k = grant_n + 1;
      m = back_n + 1;
      tx_base = tx_sum;
      send_req(3'(i), 4'h0, {5'h00, 3'(i + 1)});
      wait_for(grant_n, k, "grant");
      chk("grant byte", {2'h0, 3'(i + 1), 3'(i)}, last_grant);
      for (j = 0; j < 3; j++) begin
        tx_valid = 1'b1;
        tx_data = 8'(16 * i + j + 1);
        tx_last = (j == 2);
        k = txr_n + 1;
        wait_for(txr_n, k, "tx byte");
      end
      tx_valid = 1'b0;
      tx_last = 1'b0;
      wait_for(back_n, m, "retake");
      chk("tx bytes on bus", 48 * i + 6, tx_sum - tx_base);
    end
    $display("test transmit done");
    // Receive with a stall in mid-packet; filler must not reach the user
    k = end_n + 1;
    for (j = 0; j < 4; j++) begin
      dev_valid = 1'b1;
      dev_data = rxb[j];
      dev_last = (j == 3);
      m = dr_n + 1;
      wait_for(dr_n, m, "rx byte");
      if (j == 1) begin
        dev_valid = 1'b0;
        repeat (50) tick();
      end
    end
    dev_valid = 1'b0;
    dev_last = 1'b0;
    wait_for(end_n, k, "rx end");
    chk("rx count", 4, rx_n);
    chk("rx first flags", 1, first_n);
    chk("rx speed byte", 8'h02, first_b);
    chk("rx sum", 104, rx_sum);
    $display("test receive done");
    // Device-only reset while idle, then device still serves
    physical_layer_reset = 1'b1;
    repeat (5) tick();
    physical_layer_reset = 1'b0;
    repeat (5) tick();
    chk("phy_oe", 1, bus.phy_oe);
    send_req(REQ_EVT, 4'h5, 8'h00);
    wait_for(evt_n, 2, "event");
    chk("evt_code", 4'h5, last_evt);
    // Handover with the two bus clocks now out of step
    k = grant_n + 1;
    m = back_n + 1;
    tx_base = tx_sum;
    send_req(REQ_FAIR, 4'h0, 8'h01);
    wait_for(grant_n, k, "grant");
    chk("grant byte", {2'h0, 3'h1, REQ_FAIR}, last_grant);
    {tx_valid, tx_last, tx_data} = 10'h3aa;
    k = txr_n + 1;
    wait_for(txr_n, k, "tx byte");
    {tx_valid, tx_last} = 2'h0;
    wait_for(back_n, m, "retake");
    chk("tx bytes on bus", 8'haa, tx_sum - tx_base);
    $display("test device reset done");
    conclude();
  end
endmodule : test_phy_link_interface

// *** rtl/pli_bus_if.sv ***
`timescale 1ns/1ps
interface pli_bus_if;
  import pli_pkg::*;
  logic       link_request_out;   // Serial request from link
  logic       link_side_clock;    // Link-made bus clock
  logic       phy_clock;          // Device-made bus clock
  logic [1:0] ctl_phy;            // Device control drive
  logic [1:0] ctl_link;           // Link control drive
  logic [7:0] d_phy;              // Device data drive
  logic [7:0] d_link;             // Link data drive
  logic       phy_oe;             // Device drives both buses
  logic       link_oe;            // Link drives both buses
  logic       link_request_in;    // Request as seen at device
  logic       link_request_clock; // Link clock as seen at device
  logic [1:0] phase_control_bus;  // Resolved control wire
  logic [7:0] data_bus;           // Resolved data wire

  assign link_request_in    = link_request_out;
  assign link_request_clock = link_side_clock;
  // Undriven bus reads as idle, as a weak pull would give
  assign phase_control_bus = phy_oe ? ctl_phy : (link_oe ? ctl_link : CTL_IDLE);
  assign data_bus          = phy_oe ? d_phy : (link_oe ? d_link : 8'h00);

  modport phy_end (
    input  link_request_in, link_request_clock, phase_control_bus, data_bus,
    output phy_clock, ctl_phy, d_phy, phy_oe
  );
  modport link_end (
    input  phy_clock, phase_control_bus, data_bus,
    output link_request_out, link_side_clock, ctl_link, d_link, link_oe
  );
endinterface : pli_bus_if

// *** rtl/pli_link_end.sv ***
// Function
// R1: Link requests transmit, register access, events serially
// R2: Request bits follow the link request clock
// R3: Two-bit control bus shows interface phase
// R4: After reset device drives, link releases buses
// R5: Device drives buses on its own clock
// R6: Link drives buses on its own clock
// R7: Data bus carries data, speed, grant type
// R8: Link request output feeds device request input
// R9: Handover and codes follow the published protocol
`timescale 1ns/1ps
module pli_link_end (
  input  wire logic       clock,
  input  wire logic       rst_n,
  pli_bus_if.link_end     bus,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_type,
  input  wire logic [3:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            granted,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_first,
  output logic            rx_end,
  output logic            stat_valid,
  output logic [3:0]      stat_addr,
  output logic [7:0]      stat_data
);
  import pli_pkg::*;

  logic [3:0]       div;       // Bus clock divider
  logic [2:0]       pclk_s;    // Device clock sync plus edge stage
  logic [1:0]       ctl_s1;    // Control sync, first stage
  logic [1:0]       ctl_s2;    // Control sync, second stage
  logic [7:0]       d_s1;      // Data sync, first stage
  logic [7:0]       d_s2;      // Data sync, second stage
  logic [REQ_W-1:0] lq;        // Outgoing frame
  logic [4:0]       lcnt;      // Bits left to send
  logic             want;      // Bus request awaiting grant
  logic             in_rx;     // Receive phase in progress
  logic             st_half;   // First status beat taken
  logic             idle1;     // One idle sample since grant
  pli_link_st_t     st;        // Ownership state

  logic             fall;      // Link clock falling edge: launch
  logic             prise;     // Device clock rising edge: sample
  logic             take_req;  // Request accepted this cycle
  logic             clr_want;  // Grant caught
  logic [REQ_W-1:0] frame;     // Frame built from the request

  assign fall     = (div == HALF_LAST) & bus.link_side_clock;
  assign prise    = pclk_s[1] & ~pclk_s[2];
  assign take_req = fall & (lcnt == 5'h00) & req_valid;
  assign clr_want = prise & (st == L_IDLE) & want & (ctl_s2 == CTL_GRANT);

  // Frame assembly, left aligned, sent most significant first
  always_comb begin
    frame = '0;
    if (req_type == REQ_WR) frame = {1'b1, req_type, req_addr, req_data, 1'b0};
    else if (req_type == REQ_RD || req_type == REQ_EVT)
      frame = {1'b1, req_type, req_addr, 1'b0, 8'h00};
    else frame = {1'b1, req_type, req_data[2:0], 1'b0, 9'h000};
  end

  // Link bus clock made from the core clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div                 <= 4'h0;
      bus.link_side_clock <= 1'b0;
    end else if (div == HALF_LAST) begin
      div                 <= 4'h0;
      bus.link_side_clock <= ~bus.link_side_clock;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Two flops on every pin from the device
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pclk_s <= 3'h0;
      ctl_s1 <= CTL_IDLE;
      ctl_s2 <= CTL_IDLE;
      d_s1   <= 8'h00;
      d_s2   <= 8'h00;
    end else begin
      pclk_s <= {pclk_s[1:0], bus.phy_clock};
      ctl_s1 <= bus.phase_control_bus;
      ctl_s2 <= ctl_s1;
      d_s1   <= bus.data_bus;
      d_s2   <= d_s1;
    end
  end

  // Serial request sender; bits change on falling edges so the
  // device, sampling on rises, sees them settled
  always_ff @(posedge clock) begin
    req_ready <= 1'b0;
    if (!rst_n) begin
      lq                   <= '0;
      lcnt                 <= 5'h00;
      bus.link_request_out <= 1'b0;
    end else if (fall) begin
      if (lcnt != 5'h00) begin
        bus.link_request_out <= lq[REQ_W-1];  // see R2
        lq                   <= {lq[REQ_W-2:0], 1'b0};
        lcnt                 <= lcnt - 5'h01;
      end else if (req_valid) begin
        bus.link_request_out <= frame[REQ_W-1];  // see R1, see R8
        lq                   <= {frame[REQ_W-2:0], 1'b0};
        lcnt                 <= pli_req_len(req_type) - 5'h01;
        req_ready            <= 1'b1;
      end else begin
        bus.link_request_out <= 1'b0;  // Line rests low
      end
    end
  end

  // Grant tracking; a fresh bus request wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) want <= 1'b0;
    else if (take_req && req_type < REQ_RD) want <= 1'b1;
    else if (clr_want) want <= 1'b0;
  end

  // Receive and status capture while the device owns the buses
  always_ff @(posedge clock) begin
    rx_valid   <= 1'b0;
    rx_end     <= 1'b0;
    stat_valid <= 1'b0;
    if (!rst_n) begin
      rx_data   <= 8'h00;
      rx_first  <= 1'b0;
      in_rx     <= 1'b0;
      st_half   <= 1'b0;
      stat_addr <= 4'h0;
      stat_data <= 8'h00;
    end else if (prise && st == L_IDLE) begin
      unique case (ctl_s2)
        CTL_RECEIVE: begin  // see R7
          // First byte of a receive is its speed code
          rx_valid <= (d_s2 != DATA_ON) | ~in_rx;
          rx_data  <= d_s2;
          rx_first <= ~in_rx;
          in_rx    <= 1'b1;
        end
        CTL_STATUS: begin  // see R3
          st_half <= ~st_half;
          if (!st_half) stat_addr <= d_s2[7:4];
          else begin
            stat_data  <= d_s2;
            stat_valid <= 1'b1;
          end
        end
        CTL_IDLE: begin
          rx_end  <= in_rx;
          in_rx   <= 1'b0;
          st_half <= 1'b0;
        end
        CTL_GRANT: begin
          in_rx   <= 1'b0;
          st_half <= 1'b0;
        end
      endcase
    end
  end

  // Ownership machine; link drives only between grant and release
  always_ff @(posedge clock) begin
    tx_ready <= 1'b0;
    granted  <= 1'b0;
    if (!rst_n) begin
      st           <= L_IDLE;
      bus.link_oe  <= 1'b0;  // see R4
      bus.ctl_link <= CTL_IDLE;
      bus.d_link   <= 8'h00;
      idle1        <= 1'b0;
    end else begin
      unique case (st)
        L_IDLE: if (clr_want) begin  // see R9
          st      <= L_GRANTED;
          granted <= 1'b1;
          idle1   <= 1'b0;
        end
        // Two idle samples: the device has let go, whatever the clock phases
        L_GRANTED: if (prise && ctl_s2 == CTL_IDLE) begin
          idle1 <= 1'b1;
          if (idle1) st <= L_TX;
        end
        L_TX: if (fall) begin  // see R6
          bus.link_oe  <= 1'b1;
          bus.ctl_link <= CTL_HOLD;  // Source stalled: keep bus held
          bus.d_link   <= 8'h00;
          if (tx_valid) begin
            bus.ctl_link <= CTL_TRANSMIT;  // see R3
            bus.d_link   <= tx_data;       // see R7
            tx_ready     <= 1'b1;
            if (tx_last) st <= L_END;
          end
        end
        L_END: if (fall) begin
          // One idle phase, then release on the next falling edge
          if (bus.ctl_link != CTL_IDLE) begin
            bus.ctl_link <= CTL_IDLE;
            bus.d_link   <= 8'h00;
          end else begin
            bus.link_oe <= 1'b0;
            st          <= L_IDLE;
          end
        end
        default: st <= L_IDLE;
      endcase
    end
  end
endmodule : pli_link_end

// *** rtl/pli_phy_end.sv ***
`timescale 1ns/1ps
module pli_phy_end (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       physical_layer_reset,
  pli_bus_if.phy_end      bus,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_last,
  output logic            rx_ready,
  output logic            evt_valid,
  output logic [3:0]      evt_code
);
  import pli_pkg::*;

  logic [3:0]          div;        // Bus clock divider
  logic [1:0]          rst_s;      // Pin reset sync
  logic [2:0]          lsc_s;      // Link clock sync plus edge stage
  logic [1:0]          lreq_s;     // Request sync
  logic [1:0]          ctl_s1;     // Control sync, first stage
  logic [1:0]          ctl_s2;     // Control sync, second stage
  logic                busy;       // Frame in progress
  logic [4:0]          cnt;        // Bits received
  logic [2:0]          typ;        // Frame type
  logic [REQ_W-1:0]    sr;         // Frame shifter
  logic                bus_pend;   // Bus request waiting
  logic                rd_pend;    // Register read waiting
  logic [3:0]          rd_addr;    // Register to report
  logic [5:0]          gdata;      // Grant type and speed
  logic [3:0]          arb;        // Arbitration countdown
  logic                seen;       // Link has driven non-idle
  logic                beat2;      // Status data beat already sent
  logic                idle1;      // One idle sample since link drove
  logic [7:0]          regs [16];  // Device register file
  pli_phy_st_t         st;         // Handover state

  logic             prst;        // Combined synchronous reset
  logic             fall;        // Bus clock falling edge: launch
  logic             lrise;       // Link clock rising edge: sample
  logic [REQ_W-1:0] next_sr;     // Shifter with new bit
  logic             done;        // Last frame bit arriving
  logic             clr_bus;     // Grant issued
  logic             clr_rd;      // Status issued

  assign prst    = ~rst_n | rst_s[1];
  assign fall    = (div == HALF_LAST) & bus.phy_clock;
  assign lrise   = lsc_s[1] & ~lsc_s[2];
  assign next_sr = {sr[REQ_W-2:0], lreq_s[1]};
  assign done    = busy & lrise & (cnt >= HDR_LEN) & (cnt + 5'h01 == pli_req_len(typ));
  assign clr_rd  = fall & (st == P_IDLE) & rd_pend;
  assign clr_bus = fall & (st == P_IDLE) & ~rd_pend & bus_pend & (arb == 4'h0);

  // Bus clock made here from the core clock
  always_ff @(posedge clock) begin
    if (prst) begin
      div           <= 4'h0;
      bus.phy_clock <= 1'b0;
    end else if (div == HALF_LAST) begin
      div           <= 4'h0;
      bus.phy_clock <= ~bus.phy_clock;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Two flops on every pin from the far side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rst_s  <= 2'h0;
      lsc_s  <= 3'h0;
      lreq_s <= 2'h0;
      ctl_s1 <= CTL_IDLE;
      ctl_s2 <= CTL_IDLE;
    end else begin
      rst_s  <= {rst_s[0], physical_layer_reset};
      lsc_s  <= {lsc_s[1:0], bus.link_request_clock};  // see R2
      lreq_s <= {lreq_s[0], bus.link_request_in};       // see R2
      ctl_s1 <= bus.phase_control_bus;
      ctl_s2 <= ctl_s1;
    end
  end

  // Serial request deframer, sampled on link clock rises
  always_ff @(posedge clock) begin
    if (prst) begin
      busy <= 1'b0;
      cnt  <= 5'h00;
      typ  <= REQ_IMM;
      sr   <= '0;
    end else if (lrise) begin
      if (!busy) begin
        busy <= lreq_s[1];  // Start bit opens a frame
        cnt  <= 5'h01;
        sr   <= {{(REQ_W-1){1'b0}}, lreq_s[1]};
      end else begin
        sr  <= next_sr;
        cnt <= cnt + 5'h01;
        if (cnt == HDR_LEN - 5'h01) typ <= next_sr[2:0];
        if (done) busy <= 1'b0;
      end
    end
  end

  // Decoded requests; a new request wins over its clear
  always_ff @(posedge clock) begin
    evt_valid <= 1'b0;
    if (prst) begin
      bus_pend <= 1'b0;
      rd_pend  <= 1'b0;
      rd_addr  <= 4'h0;
      gdata    <= 6'h00;
      evt_code <= 4'h0;
    end else begin
      if (clr_bus) bus_pend <= 1'b0;
      if (clr_rd) rd_pend <= 1'b0;
      if (done && typ < REQ_RD) begin  // see R1
        bus_pend <= 1'b1;
        gdata    <= {next_sr[3:1], typ};
      end
      if (done && typ == REQ_RD) begin
        rd_pend <= 1'b1;
        rd_addr <= next_sr[4:1];
      end
      if (done && typ == REQ_EVT) begin
        evt_valid <= 1'b1;
        evt_code  <= next_sr[4:1];
      end
    end
  end

  // Register writes carried in on the request line
  always_ff @(posedge clock) begin
    if (done && typ == REQ_WR) regs[next_sr[12:9]] <= next_sr[8:1];
  end

  // Arbitration delay before a grant
  always_ff @(posedge clock) begin
    if (prst || !bus_pend) arb <= ARB_WAIT;
    else if (fall && arb != 4'h0) arb <= arb - 4'h1;
  end

  // Handover machine; every bus change launches on a falling edge
  always_ff @(posedge clock) begin
    rx_ready <= 1'b0;
    if (prst) begin
      st          <= P_IDLE;
      bus.phy_oe  <= 1'b1;      // see R4
      bus.ctl_phy <= CTL_IDLE;  // see R4
      bus.d_phy   <= 8'h00;
      seen        <= 1'b0;
      beat2       <= 1'b0;
      idle1       <= 1'b0;
    end else begin
      unique case (st)
        P_IDLE: if (fall) begin  // see R5
          bus.phy_oe  <= 1'b1;
          bus.ctl_phy <= CTL_IDLE;
          bus.d_phy   <= 8'h00;
          if (rd_pend) begin  // Status: address first
            st          <= P_STAT;
            bus.ctl_phy <= CTL_STATUS;  // see R3
            bus.d_phy   <= {rd_addr, 4'h0};
          end else if (clr_bus) begin
            st          <= P_GRANT;
            bus.ctl_phy <= CTL_GRANT;
            bus.d_phy   <= {2'h0, gdata};  // see R7
          end else if (rx_valid) begin
            st          <= P_RECV;
            bus.ctl_phy <= CTL_RECEIVE;
            bus.d_phy   <= rx_data;
            rx_ready    <= 1'b1;
            if (rx_last) st <= P_STAT;  // One byte: close next edge
          end
        end
        P_STAT: if (fall) begin
          // Second status beat carries data, closing beat idles; a flag,
          // not the byte, marks the beat so any register value is safe
          if (bus.ctl_phy == CTL_STATUS && !beat2) begin
            bus.d_phy <= regs[rd_addr];
            beat2     <= 1'b1;
          end else begin
            st          <= P_IDLE;
            bus.ctl_phy <= CTL_IDLE;
            bus.d_phy   <= 8'h00;
            beat2       <= 1'b0;
          end
        end
        P_RECV: if (fall) begin
          bus.d_phy <= DATA_ON;  // Stalled source: data-on filler
          if (rx_valid) begin
            bus.d_phy <= rx_data;  // see R7
            rx_ready  <= 1'b1;
            if (rx_last) st <= P_STAT;
          end
        end
        P_GRANT: if (fall) begin  // see R9
          st          <= P_REL;
          bus.ctl_phy <= CTL_IDLE;
          bus.d_phy   <= 8'h00;
        end
        P_REL: if (fall) begin
          st         <= P_LINK;
          bus.phy_oe <= 1'b0;  // Link owns the buses now
          seen       <= 1'b0;
          idle1      <= 1'b0;
        end
        P_LINK: if (lrise) begin
          // Link closes with an idle phase; two idle samples in a row
          // prove it has let go, whatever the phase of the two clocks
          if (ctl_s2 != CTL_IDLE) begin
            seen  <= 1'b1;
            idle1 <= 1'b0;
          end else if (seen) begin
            idle1 <= 1'b1;
            if (idle1) st <= P_IDLE;
          end
        end
        default: st <= P_IDLE;
      endcase
    end
  end
endmodule : pli_phy_end

// *** rtl/pli_pkg.sv ***
package pli_pkg;
  // Core clock and the bus clock each end makes by division
  localparam int CLK_NS        = 4;
  localparam int BUS_PERIOD_NS = 80;
  localparam int HALF_CYC      = BUS_PERIOD_NS / 2 / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  // Bus clock periods the device waits before granting
  localparam logic [3:0] ARB_WAIT  = 4'h4;

  // Phase codes while the device drives the control bus
  localparam logic [1:0] CTL_IDLE    = 2'h0;
  localparam logic [1:0] CTL_STATUS  = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT   = 2'h3;
  // Phase codes while the link drives the control bus
  localparam logic [1:0] CTL_HOLD     = 2'h1;
  localparam logic [1:0] CTL_TRANSMIT = 2'h2;
  // Filler byte while a receive waits for data
  localparam logic [7:0] DATA_ON = 8'hff;

  // Serial request types
  localparam logic [2:0] REQ_IMM  = 3'h0;
  localparam logic [2:0] REQ_ISO  = 3'h1;
  localparam logic [2:0] REQ_PRI  = 3'h2;
  localparam logic [2:0] REQ_FAIR = 3'h3;
  localparam logic [2:0] REQ_RD   = 3'h4;
  localparam logic [2:0] REQ_WR   = 3'h5;
  localparam logic [2:0] REQ_EVT  = 3'h6;
  // Serial frame: start, type, payload, stop; longest is 17 bits
  localparam int REQ_W = 17;
  localparam logic [4:0] LEN_BUS = 5'h08;
  localparam logic [4:0] LEN_ADR = 5'h09;
  localparam logic [4:0] LEN_WR  = 5'h11;
  localparam logic [4:0] HDR_LEN = 5'h04;

  typedef enum logic [5:0] {
    P_IDLE = 6'h01, P_GRANT = 6'h02, P_REL = 6'h04,
    P_LINK = 6'h08, P_STAT = 6'h10, P_RECV = 6'h20
  } pli_phy_st_t;
  typedef enum logic [3:0] {
    L_IDLE = 4'h1, L_GRANTED = 4'h2, L_TX = 4'h4, L_END = 4'h8
  } pli_link_st_t;

  // Frame length in bits, shared by sender and receiver
  function automatic logic [4:0] pli_req_len(input logic [2:0] t);
    if (t == REQ_WR) return LEN_WR;
    else if (t == REQ_RD || t == REQ_EVT) return LEN_ADR;
    else return LEN_BUS;
  endfunction : pli_req_len
endpackage : pli_pkg
